// File: hdl/pcd_pkg.sv
package pcd_pkg;
    // Logic clock period
    localparam int PCD_CLK_NS = 100;

    // Register map, byte addresses
    localparam logic [7:0] PCD_ADDR_MODE   = 8'h00;
    localparam logic [7:0] PCD_ADDR_SRC    = 8'h04;
    localparam logic [7:0] PCD_ADDR_FMT    = 8'h08;
    localparam logic [7:0] PCD_ADDR_POS    = 8'h0C;
    localparam logic [7:0] PCD_ADDR_STATUS = 8'h10;

    // Control mode codes
    localparam logic [3:0] PCD_MODE_EXT = 4'h1;
    localparam logic [3:0] PCD_MODE_INT = 4'h5;

    // Source select bit positions
    localparam int PCD_SRC_SLOW = 0;
    localparam int PCD_SRC_FAST = 1;
    localparam int PCD_SRC_INT  = 2;
    localparam int PCD_SRC_CAM  = 3;

    // Format register digit positions
    localparam int PCD_FMT_LSB  = 0;
    localparam int PCD_FILT_LSB = 4;
    localparam int PCD_POL_LSB  = 8;

    // Pulse format codes
    localparam logic [3:0] PCD_FMT_STEP_DIR = 4'h0;
    localparam logic [3:0] PCD_FMT_CW_CCW   = 4'h1;
    localparam logic [3:0] PCD_FMT_QUAD     = 4'h2;

    // Line polarity codes
    localparam logic [3:0] PCD_POL_NN   = 4'h0;
    localparam logic [3:0] PCD_POL_PP   = 4'h1;
    localparam logic [3:0] PCD_POL_NP   = 4'h2;
    localparam logic [3:0] PCD_POL_PN   = 4'h3;
    localparam logic [3:0] PCD_POL_SWAP = 4'h4;

    // Reset values
    localparam logic [3:0]  PCD_MODE_RST = 4'h1;
    localparam logic [3:0]  PCD_SRC_RST  = 4'h1;
    localparam logic [11:0] PCD_FMT_RST  = 12'h100;

    // Highest line rates, kHz
    localparam int PCD_SLOW_DIFF_MAX_KHZ = 500;
    localparam int PCD_SLOW_OC_MAX_KHZ   = 200;
    localparam int PCD_FAST_MAX_KHZ      = 4000;

    // Filter cutoffs, kHz, codes 0 to 6
    localparam int PCD_FILT_CODES = 7;
    localparam int PCD_FILT_KHZ [PCD_FILT_CODES] = '{4000, 2000, 1000, 500, 200, 150, 80};

    // Half the filter time in clock cycles, rounded up
    function automatic logic [7:0] pcd_filt_cycles(input int khz);
        pcd_filt_cycles = 8'((500_000 + khz * PCD_CLK_NS - 1) / (khz * PCD_CLK_NS));
    endfunction : pcd_filt_cycles

    // Decoded command increment towards the gear stage
    typedef struct packed {
        logic              valid;
        logic signed [9:0] inc;
    } pcd_cmd_t;

    // One pulse line and its direction line
    typedef struct packed {
        logic pulse;
        logic dir;
    } pcd_pair_t;
endpackage : pcd_pkg

// File: hdl/pcd_glitch_filter.sv
`timescale 1ns/1ps
`default_nettype none
module pcd_glitch_filter #(
    parameter int W = 8
) (
    input  wire logic         i_clk,
    input  wire logic         i_resetn,
    input  wire logic         i_line,
    input  wire logic [W-1:0] i_len,
    output var  logic         o_level
);
    logic         sync1_r;
    logic         sync2_r;
    logic [W-1:0] cnt_r;

    // Two-flop synchroniser, first stage read only by the second
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= i_line;
            sync2_r <= sync1_r;
        end
    end

    // New level taken only once it has persisted i_len cycles
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_r   <= '0;
            o_level <= 1'b0;
        end else if (sync2_r == o_level) begin
            cnt_r <= '0; // Glitch ended early, discard it [RQ7]
        end else if (cnt_r + W'(1) >= i_len) begin
            cnt_r   <= '0;
            o_level <= sync2_r; // [RQ14]
        end else begin
            cnt_r <= cnt_r + W'(1);
        end
    end

    property p_filt_persist;
        @(posedge i_clk) disable iff (!i_resetn)
        $changed(o_level) |-> ($past(cnt_r) + W'(1) >= $past(i_len));
    endproperty
    a_filt_persist: assert property (p_filt_persist) // [RQ14]
        else $error("Filter level changed before the interval ran out");

    property p_filt_short;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_len == W'(2) && sync2_r != o_level) ##1 (sync2_r == o_level) |=>
            $stable(o_level);
    endproperty
    a_filt_short: assert property (p_filt_short) // [RQ7]
        else $error("One-cycle glitch reached the filtered level");
endmodule : pcd_glitch_filter
`default_nettype wire

// File: hdl/pcd_decoder.sv
// Summary of operation
// RQ1: Mode code 1 runs external pulse path; code 5 runs internal position path.
// RQ2: Four source enables: low-speed, high-speed, internal pulses, cam pulses; 1 on.
// RQ3: Command increment is the sum of increments from all enabled sources.
// RQ4: Low-speed input counts up to 500 kHz differential, 200 kHz open collector.
// RQ5: High-speed differential input counts up to 4 MHz; host stays below.
// RQ6: Filter codes 0 to 6 select 4M, 2M, 1M, 500k, 200k, 150k, 80k cutoff.
// RQ7: Disturbances shorter than half the filter time produce no count or direction.
// RQ8: Format digit selects step plus direction, CW plus CCW, or quadrature.
// RQ9: Quadrature count and direction come from phase of two 90 degree channels.
// RQ10: Polarity codes 0 to 3 set pulse and direction line logic sense.
// RQ11: Polarity code 4 swaps pulse and direction lines before decoding.
// RQ12: Changing line logic inverts decoded direction for the same host command; code inverts it only for the step/dir direction line or one quadrature line.
// RQ13: Increments in command units go to the gear scaling stage.
// RQ14: Filter accepts a synchronised level change only after it persists.
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pcd_decoder #(
    parameter int FW = 8
) (
    input  wire logic              i_clk,
    input  wire logic              i_resetn,
    input  wire logic [7:0]        i_addr,
    input  wire logic [31:0]       i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output var  logic [31:0]       o_rdata,
    input  wire logic              i_low_speed_pulse_line,
    input  wire logic              i_low_speed_direction_line,
    input  wire logic              i_fast_pulse_line_pos,
    input  wire logic              i_fast_pulse_line_neg,
    input  wire logic              i_fast_direction_line_pos,
    input  wire logic              i_fast_direction_line_neg,
    input  wire logic signed [7:0] i_int_inc,
    input  wire logic signed [7:0] i_cam_inc,
    output var  pcd_pkg::pcd_cmd_t o_cmd
);
    logic [3:0]         mode_r;
    logic [3:0]         src_r;
    logic [11:0]        fmt_r;
    logic signed [31:0] pos_r;
    logic [FW-1:0]      len_r;
    logic [5:0]         lvl;
    pcd_pkg::pcd_pair_t slow_raw;
    pcd_pkg::pcd_pair_t fast_raw;
    pcd_pkg::pcd_pair_t slow_c;
    pcd_pkg::pcd_pair_t fast_c;
    pcd_pkg::pcd_pair_t slow_p_r;
    pcd_pkg::pcd_pair_t fast_p_r;
    logic [3:0]         fmt_code;
    logic [3:0]         filt_code;
    logic [3:0]         pol_code;
    logic               ext_on;
    logic               int_on;
    logic signed [1:0]  slow_d;
    logic signed [1:0]  fast_d;
    logic signed [9:0]  slow_t;
    logic signed [9:0]  fast_t;
    logic signed [9:0]  int_t;
    logic signed [9:0]  cam_t;
    logic signed [9:0]  sum_nxt;

    assign fmt_code  = fmt_r[pcd_pkg::PCD_FMT_LSB +: 4];
    assign filt_code = fmt_r[pcd_pkg::PCD_FILT_LSB +: 4];
    assign pol_code  = fmt_r[pcd_pkg::PCD_POL_LSB +: 4];

    // Line polarity and swap ahead of the decoder
    function automatic pcd_pkg::pcd_pair_t cond(input pcd_pkg::pcd_pair_t r,
                                                input logic [3:0] pol);
        pcd_pkg::pcd_pair_t c;
        c = r;
        case (pol)
            pcd_pkg::PCD_POL_NN: c = '{pulse: ~r.pulse, dir: ~r.dir};
            pcd_pkg::PCD_POL_NP: c = '{pulse: ~r.pulse, dir: r.dir};
            pcd_pkg::PCD_POL_PN: c = '{pulse: r.pulse, dir: ~r.dir};
            pcd_pkg::PCD_POL_SWAP: c = '{pulse: r.dir, dir: r.pulse};
            default: c = r; // Positive logic, also for unused codes
        endcase
        return c;
    endfunction : cond

    // Step decode from previous and present line levels
    function automatic logic signed [1:0] dec(input pcd_pkg::pcd_pair_t p,
                                              input pcd_pkg::pcd_pair_t c,
                                              input logic [3:0] fmt);
        logic signed [1:0] d;
        d = 2'sd0;
        case (fmt)
            pcd_pkg::PCD_FMT_STEP_DIR: begin
                if (c.pulse && !p.pulse) begin
                    d = c.dir ? 2'sd1 : -2'sd1;
                end
            end
            pcd_pkg::PCD_FMT_CW_CCW: begin
                if (c.pulse && !p.pulse && !(c.dir && !p.dir)) begin
                    d = 2'sd1;
                end else if (c.dir && !p.dir && !(c.pulse && !p.pulse)) begin
                    d = -2'sd1;
                end
            end
            pcd_pkg::PCD_FMT_QUAD: begin
                // Exactly one channel moved; its phase gives the sense
                if ((c.pulse ^ p.pulse) != (c.dir ^ p.dir)) begin
                    d = (p.pulse == c.dir) ? 2'sd1 : -2'sd1;
                end
            end
            default: d = 2'sd0; // Unused format codes never count
        endcase
        return d;
    endfunction : dec

    // Register writes; writing the position register clears it
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mode_r <= pcd_pkg::PCD_MODE_RST;
            src_r  <= pcd_pkg::PCD_SRC_RST;
            fmt_r  <= pcd_pkg::PCD_FMT_RST;
        end else if (i_wr) begin
            case (i_addr)
                pcd_pkg::PCD_ADDR_MODE: mode_r <= i_wdata[3:0];
                pcd_pkg::PCD_ADDR_SRC:  src_r  <= i_wdata[3:0]; // [RQ2]
                pcd_pkg::PCD_ADDR_FMT:  fmt_r  <= i_wdata[11:0];
                default: ;
            endcase
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            case (i_addr)
                pcd_pkg::PCD_ADDR_MODE:   o_rdata <= {28'h000_0000, mode_r};
                pcd_pkg::PCD_ADDR_SRC:    o_rdata <= {28'h000_0000, src_r};
                pcd_pkg::PCD_ADDR_FMT:    o_rdata <= {20'h0_0000, fmt_r};
                pcd_pkg::PCD_ADDR_POS:    o_rdata <= pos_r;
                pcd_pkg::PCD_ADDR_STATUS: o_rdata <= {24'h00_0000, ext_on, int_on, lvl};
                default:                  o_rdata <= 32'h0000_0000;
            endcase
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

    // Filter length from cutoff code; out-of-range codes use the slowest
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            len_r <= FW'(pcd_pkg::pcd_filt_cycles(pcd_pkg::PCD_FILT_KHZ[0]));
        end else begin
            case (filt_code)
                4'h0: len_r <= FW'(pcd_pkg::pcd_filt_cycles(pcd_pkg::PCD_FILT_KHZ[0])); // [RQ6]
                4'h1: len_r <= FW'(pcd_pkg::pcd_filt_cycles(pcd_pkg::PCD_FILT_KHZ[1]));
                4'h2: len_r <= FW'(pcd_pkg::pcd_filt_cycles(pcd_pkg::PCD_FILT_KHZ[2]));
                4'h3: len_r <= FW'(pcd_pkg::pcd_filt_cycles(pcd_pkg::PCD_FILT_KHZ[3]));
                4'h4: len_r <= FW'(pcd_pkg::pcd_filt_cycles(pcd_pkg::PCD_FILT_KHZ[4]));
                4'h5: len_r <= FW'(pcd_pkg::pcd_filt_cycles(pcd_pkg::PCD_FILT_KHZ[5]));
                default: len_r <= FW'(pcd_pkg::pcd_filt_cycles(pcd_pkg::PCD_FILT_KHZ[6]));
            endcase
        end
    end

    // One synchroniser and glitch filter per pin [RQ4] [RQ7]
    pcd_glitch_filter #(.W(FW)) u_f0 (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_line   (i_low_speed_pulse_line),
        .i_len    (len_r),
        .o_level  (lvl[0])
    );
    pcd_glitch_filter #(.W(FW)) u_f1 (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_line   (i_low_speed_direction_line),
        .i_len    (len_r),
        .o_level  (lvl[1])
    );
    pcd_glitch_filter #(.W(FW)) u_f2 (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_line   (i_fast_pulse_line_pos),
        .i_len    (len_r),
        .o_level  (lvl[2])
    );
    pcd_glitch_filter #(.W(FW)) u_f3 (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_line   (i_fast_pulse_line_neg),
        .i_len    (len_r),
        .o_level  (lvl[3])
    );
    pcd_glitch_filter #(.W(FW)) u_f4 (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_line   (i_fast_direction_line_pos),
        .i_len    (len_r),
        .o_level  (lvl[4])
    );
    pcd_glitch_filter #(.W(FW)) u_f5 (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_line   (i_fast_direction_line_neg),
        .i_len    (len_r),
        .o_level  (lvl[5])
    );

    // Differential receive after filtering; equal legs read as low [RQ5]
    assign slow_raw = '{pulse: lvl[0], dir: lvl[1]};
    assign fast_raw = '{pulse: lvl[2] & ~lvl[3], dir: lvl[4] & ~lvl[5]};

    // Polarity and swap; a negated step/dir direction line or one negated quadrature line flips the count direction [RQ10] [RQ11] [RQ12]
    assign slow_c = cond(slow_raw, pol_code);
    assign fast_c = cond(fast_raw, pol_code);

    // Previous conditioned levels for edge and phase detection
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            slow_p_r <= '0;
            fast_p_r <= '0;
        end else begin
            slow_p_r <= slow_c;
            fast_p_r <= fast_c;
        end
    end

    // Format decode [RQ8] [RQ9]
    assign slow_d = dec(slow_p_r, slow_c, fmt_code);
    assign fast_d = dec(fast_p_r, fast_c, fmt_code);

    // Mode gating of the command path [RQ1]
    assign ext_on = (mode_r == pcd_pkg::PCD_MODE_EXT);
    assign int_on = ext_on || (mode_r == pcd_pkg::PCD_MODE_INT);

    // Per-source terms, zero when a source is off [RQ2]
    assign slow_t = (ext_on && src_r[pcd_pkg::PCD_SRC_SLOW]) ? {{8{slow_d[1]}}, slow_d} : '0;
    assign fast_t = (ext_on && src_r[pcd_pkg::PCD_SRC_FAST]) ? {{8{fast_d[1]}}, fast_d} : '0;
    assign int_t  = (int_on && src_r[pcd_pkg::PCD_SRC_INT]) ? {{2{i_int_inc[7]}}, i_int_inc} : '0;
    assign cam_t  = (ext_on && src_r[pcd_pkg::PCD_SRC_CAM]) ? {{2{i_cam_inc[7]}}, i_cam_inc} : '0;

    // Effective command is the sum of all enabled sources [RQ3]
    assign sum_nxt = slow_t + fast_t + int_t + cam_t;

    // Increment handed on, in command units, to the gear stage [RQ13]
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_cmd <= '0;
        end else begin
            o_cmd.inc   <= sum_nxt;
            o_cmd.valid <= (sum_nxt != 10'sd0);
        end
    end

    // Command position monitor; a write clears it
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pos_r <= '0;
        end else if (i_wr && i_addr == pcd_pkg::PCD_ADDR_POS) begin
            pos_r <= '0;
        end else begin
            pos_r <= pos_r + {{22{o_cmd.inc[9]}}, o_cmd.inc};
        end
    end

    // Checks on the command path
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    property p_mode_off;
        (mode_r != pcd_pkg::PCD_MODE_EXT && mode_r != pcd_pkg::PCD_MODE_INT) |=>
            (o_cmd.inc == 10'sd0);
    endproperty
    a_mode_off: assert property (p_mode_off) // [RQ1]
        else $error("Command moved outside the position modes");

    property p_int_mode;
        (mode_r == pcd_pkg::PCD_MODE_INT) |-> (slow_t == 10'sd0 && fast_t == 10'sd0);
    endproperty
    a_int_mode: assert property (p_int_mode) // [RQ1]
        else $error("Pin pulses counted in internal register mode");

    property p_src_off;
        !src_r[pcd_pkg::PCD_SRC_SLOW] && !src_r[pcd_pkg::PCD_SRC_FAST] &&
        !src_r[pcd_pkg::PCD_SRC_CAM] && !src_r[pcd_pkg::PCD_SRC_INT] |=>
            (o_cmd.inc == 10'sd0);
    endproperty
    a_src_off: assert property (p_src_off) // [RQ2]
        else $error("Command moved with every source off");

    property p_sum;
        ext_on && (&src_r) && i_int_inc == 8'sd3 && i_cam_inc == -8'sd1 |=>
            (o_cmd.inc == 10'sd2 + $past(slow_t) + $past(fast_t));
    endproperty
    a_sum: assert property (p_sum) // [RQ3]
        else $error("Command is not the sum of enabled sources");

    property p_filt_len;
        (filt_code == 4'h0) ##1 (filt_code == 4'h0) |-> (len_r == FW'(2));
    endproperty
    a_filt_len: assert property (p_filt_len) // [RQ6]
        else $error("Fastest cutoff does not give two cycles");

    property p_bad_fmt;
        (fmt_code > pcd_pkg::PCD_FMT_QUAD) |-> (slow_d == 2'sd0 && fast_d == 2'sd0);
    endproperty
    a_bad_fmt: assert property (p_bad_fmt) // [RQ8]
        else $error("Unused format code produced a count");

    property p_quad_dir;
        (fmt_code == pcd_pkg::PCD_FMT_QUAD && slow_p_r == 2'b00 && slow_c == 2'b10) |->
            (slow_d == 2'sd1);
    endproperty
    a_quad_dir: assert property (p_quad_dir) // [RQ9]
        else $error("Leading pulse channel did not count forward");

    property p_step_dir;
        (fmt_code == pcd_pkg::PCD_FMT_STEP_DIR && slow_c.pulse && !slow_p_r.pulse) |->
            (slow_d == (slow_c.dir ? 2'sd1 : -2'sd1));
    endproperty
    a_step_dir: assert property (p_step_dir) // [RQ10]
        else $error("Step direction does not follow the direction line");

    property p_swap;
        (pol_code == pcd_pkg::PCD_POL_SWAP) |-> (slow_c.pulse == lvl[1] && slow_c.dir == lvl[0]);
    endproperty
    a_swap: assert property (p_swap) // [RQ11]
        else $error("Pulse and direction lines not swapped");

    property p_invert;
        (pol_code == pcd_pkg::PCD_POL_NN) |-> (slow_c.dir == !lvl[1]);
    endproperty
    a_invert: assert property (p_invert) // [RQ12]
        else $error("Negative logic did not invert the direction");

    property p_valid;
        o_cmd.valid == (o_cmd.inc != 10'sd0);
    endproperty
    a_valid: assert property (p_valid) // [RQ13]
        else $error("Command valid flag disagrees with the increment");

    property p_quad_both;
        (fmt_code == pcd_pkg::PCD_FMT_QUAD && slow_c.pulse != slow_p_r.pulse &&
            slow_c.dir != slow_p_r.dir) |-> (slow_d == 2'sd0);
    endproperty
    a_quad_both: assert property (p_quad_both) // [RQ9]
        else $error("Both quadrature channels moved yet a count was made");
endmodule : pcd_decoder
`default_nettype wire

// File: verif/pcd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host pulse generator on the far side of the pulse and direction pins
module pcd_host_model (
    input  wire logic i_clk,
    output var  logic o_a,
    output var  logic o_b
);
    logic [1:0] q_r = 2'h0;

    // Pins start at the idle level
    initial begin
        o_a = 1'h0;
        o_b = 1'h0;
    end

    // Raw wait with no minimum, used by idle, hold and pulse
    task automatic w(input int n);
        repeat (n) @(posedge i_clk);
    endtask : w

    // Level hold never shorter than the slow input allows
    task automatic hold(input int n);
        w(n < 10 ? 10 : n);
    endtask : hold

    // Back to idle lines and quadrature phase zero
    task automatic idle();
        @(posedge i_clk);
        o_a <= 1'h0;
        o_b <= 1'h0;
        q_r = 2'h0;
        w(10);
    endtask : idle

    // One high pulse of n cycles on the first line
    task automatic pulse(input int n);
        @(posedge i_clk);
        o_a <= 1'h1;
        w(n);
        o_a <= 1'h0;
        hold(10);
    endtask : pulse

    // One command step in the given format
    task automatic step(input logic fwd, input int fmt, input int h);
        @(posedge i_clk);
        if (fmt == 2) begin
            // Gray order 00,10,11,01 keeps A a quarter period ahead of B
            q_r = fwd ? q_r + 2'h1 : q_r - 2'h1;
            o_a <= q_r[1] ^ q_r[0];
            o_b <= q_r[1];
            hold(h);
        end else if (fmt == 1) begin
            o_a <= fwd;
            o_b <= ~fwd;
            hold(h);
            o_a <= 1'h0;
            o_b <= 1'h0;
            hold(h);
        end else begin
            // Direction settles a full hold before the pulse edge
            o_b <= fwd;
            hold(h);
            o_a <= 1'h1;
            hold(h);
            o_a <= 1'h0;
            hold(h);
        end
    endtask : step
endmodule : pcd_host_model
`default_nettype wire

// File: verif/pcd_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module pcd_decoder_test;
    logic              i_clk     = 1'h0;
    logic              i_resetn  = 1'h0;
    logic [7:0]        i_addr    = 8'h00;
    logic [31:0]       i_wdata   = 32'h0000_0000;
    logic              i_wr      = 1'h0;
    logic              i_rd      = 1'h0;
    logic signed [7:0] i_int_inc = 8'sh00;
    logic signed [7:0] i_cam_inc = 8'sh00;
    logic [31:0]       o_rdata;
    pcd_pkg::pcd_cmd_t o_cmd;
    logic              host_a;
    logic              host_b;
    logic              swp       = 1'h0;
    logic [31:0]       d;
    logic [31:0]       x;
    int                n_fail    = 0;
    int                checks    = 0;
    int                seed      = 36886;
    int                pm        = 1;
    int                mt [6]    = '{1, 1, 5, 1, 3, 1};
    int                st [6]    = '{5, 8, 15, 0, 15, 15};

    // Clock
    always #(pcd_pkg::PCD_CLK_NS / 2) i_clk = ~i_clk;

    // Swap wiring lets the host drive the lines the decoder expects to trade
    wire pin_p = swp ? host_b : host_a;
    wire pin_d = swp ? host_a : host_b;

    pcd_decoder #(.FW(8)) i_dut (
        .i_clk                      (i_clk),
        .i_resetn                   (i_resetn),
        .i_addr                     (i_addr),
        .i_wdata                    (i_wdata),
        .i_wr                       (i_wr),
        .i_rd                       (i_rd),
        .o_rdata                    (o_rdata),
        .i_low_speed_pulse_line     (pin_p),
        .i_low_speed_direction_line (pin_d),
        .i_fast_pulse_line_pos      (pin_p),
        .i_fast_pulse_line_neg      (~pin_p),
        .i_fast_direction_line_pos  (pin_d),
        .i_fast_direction_line_neg  (~pin_d),
        .i_int_inc                  (i_int_inc),
        .i_cam_inc                  (i_cam_inc),
        .o_cmd                      (o_cmd)
    );

    pcd_host_model i_host (
        .i_clk (i_clk),
        .o_a   (host_a),
        .o_b   (host_b)
    );

    // Verdict and end of run
    task automatic test_done();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done

    // Register write, one strobe cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= v;
        i_wr    <= 1'h1;
        @(posedge i_clk);
        i_wr    <= 1'h0;
    endtask : wr

    // Register read, data taken in the single cycle it stands
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'h1;
        @(posedge i_clk);
        i_rd   <= 1'h0;
        #1 d = o_rdata;
    endtask : rd

    // Filter hold in cycles: half the filter period, rounded up
    function automatic int flen(input int c);
        return (500_000 / pcd_pkg::PCD_FILT_KHZ[c] + 99) / 100;
    endfunction : flen

    // Sign of one forward host step; a negated direction line flips step/dir, one negated line flips quadrature
    function automatic int fsign(input int f, input int p);
        if (f > 2)
            return 0;
        if (p == 1 || p >= 4 || f == 1)
            return 1;
        if (f == 0)
            return (p == 2) ? 1 : -1;
        return (p == 0) ? 1 : -1;
    endfunction : fsign

    // Configure, settle, clear, send n random steps, compare position
    task automatic run(input int f, input int p, input int c, input int n);
        int   e;
        logic fwd;
        e = 0;
        i_host.idle();
        swp <= (p == 4);
        wr(pcd_pkg::PCD_ADDR_FMT, 32'(p * 256 + c * 16 + f));
        repeat (80) @(posedge i_clk);
        wr(pcd_pkg::PCD_ADDR_POS, 32'h0000_0000);
        for (int k = 0; k < n; k++) begin
            fwd = 1'($random(seed));
            i_host.step(fwd, f, flen(c) + 2);
            e += (fwd ? pm : -pm) * fsign(f, p);
        end
        repeat (80) @(posedge i_clk);
        rd(pcd_pkg::PCD_ADDR_POS);
        `CHK(d, 32'(e));
    endtask : run

    // Watchdog
    initial begin
        repeat (90000) @(posedge i_clk);
        n_fail++;
        test_done();
    end

    initial begin
        int                e;
        int                ev;
        logic signed [7:0] vi;
        logic signed [7:0] vc;
        repeat (2) @(posedge i_clk);
        i_resetn <= 1'h1;
        // Reset contents, and an unmapped place that ignores writes
        rd(pcd_pkg::PCD_ADDR_MODE);
        `CHK(d, 32'(pcd_pkg::PCD_MODE_RST));
        rd(pcd_pkg::PCD_ADDR_SRC);
        `CHK(d, 32'(pcd_pkg::PCD_SRC_RST));
        rd(pcd_pkg::PCD_ADDR_FMT);
        `CHK(d, 32'(pcd_pkg::PCD_FMT_RST));
        wr(8'h14, 32'hFFFF_FFFF);
        wr(pcd_pkg::PCD_ADDR_MODE, 32'h0000_0005);
        rd(8'h14);
        `CHK(d, 32'h0000_0000);
        rd(pcd_pkg::PCD_ADDR_MODE);
        `CHK(d, 32'h0000_0005);
        wr(pcd_pkg::PCD_ADDR_MODE, 32'h0000_0001);
        // Every format against every line sense, both pin inputs summed
        wr(pcd_pkg::PCD_ADDR_SRC, 32'h0000_0003);
        pm = 2;
        for (int f = 0; f < 3; f++)
            for (int p = 0; p < 5; p++)
                run(f, p, 0, 6);
        // Fast input alone
        wr(pcd_pkg::PCD_ADDR_SRC, 32'h0000_0002);
        pm = 1;
        run(0, 1, 0, 4);
        // Unused format never counts; unused polarity code reads as positive
        run(3, 1, 0, 4);
        run(0, 5, 0, 2);
        // Each filter code: a short disturbance is dropped, a held pulse counts
        wr(pcd_pkg::PCD_ADDR_SRC, 32'h0000_0001);
        for (int c = 0; c < 7; c++) begin
            run(0, 1, c, 3);
            x = d;
            i_host.idle();
            i_host.pulse(flen(c) - 1);
            repeat (80) @(posedge i_clk);
            rd(pcd_pkg::PCD_ADDR_POS);
            `CHK(d, x);
            i_host.pulse(flen(c) + 1);
            repeat (80) @(posedge i_clk);
            rd(pcd_pkg::PCD_ADDR_POS);
            `CHK(d, x - 32'h0000_0001);
        end
        // Modes and source enables with random internal and cam increments
        wr(pcd_pkg::PCD_ADDR_FMT, 32'h0000_0100);
        for (int k = 0; k < 6; k++) begin
            wr(pcd_pkg::PCD_ADDR_MODE, 32'(mt[k]));
            wr(pcd_pkg::PCD_ADDR_SRC, 32'(st[k]));
            pm = (mt[k] == 1) ? st[k] % 2 + st[k] / 2 % 2 : 0;
            i_host.idle();
            repeat (80) @(posedge i_clk);
            wr(pcd_pkg::PCD_ADDR_POS, 32'h0000_0000);
            e = pm;
            ev = 0;
            // First pair is a fixed corner, the last pair returns to zero
            for (int j = 0; j < 9; j++) begin
                vi = (j == 0) ? 8'sh03 : 8'($random(seed) % 100);
                vc = (j == 0) ? -8'sh01 : 8'($random(seed) % 100);
                if (j == 8)
                    {vi, vc} = 16'h0000;
                @(posedge i_clk);
                i_int_inc <= vi;
                i_cam_inc <= vc;
                #1 `CHK(o_cmd, {ev != 0, 10'(ev)});
                ev = 0;
                if ((mt[k] == 1 || mt[k] == 5) && st[k] / 4 % 2 == 1)
                    ev += vi;
                if (mt[k] == 1 && st[k] / 8 == 1)
                    ev += vc;
                e += ev;
            end
            i_host.step(1'h1, 0, 10);
            repeat (80) @(posedge i_clk);
            rd(pcd_pkg::PCD_ADDR_POS);
            `CHK(d, 32'(e));
            rd(pcd_pkg::PCD_ADDR_STATUS);
            `CHK(d[7], mt[k] == 1);
            `CHK(d[6], mt[k] == 1 || mt[k] == 5);
        end
        test_done();
    end
endmodule : pcd_decoder_test
`default_nettype wire
